// ### hdl/emc_clkgen.sv
/*
  Interface clock generator: picks the strapped source and makes the
  full-rate and divided output clocks plus one-cycle tick enables.
  Assumes the external clock pin already passed two flip-flops and that
  the strap code is stable after reset release.
*/
`default_nettype none
module emc_clkgen
  import emc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] strap,
  input wire logic [1:0] div_sel,
  input wire logic ext_clk_sync,
  output logic tick,
  output logic clk_full,
  output logic clk_div
);
  logic ext_prev;
  logic [2:0] cnt;
  logic [2:0] half;
  logic src_lvl;
  logic src_rise;
  logic [1:0] div_cnt;
  logic next_src_lvl;

  always_comb begin
    half = (strap == `EMC_STRAP_DIV6) ? `EMC_HALF_DIV6 : `EMC_HALF_DIV4;
  end

  // strapped cpu divide toggles a level every half period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      src_lvl <= 1'b0;
    end else if (strap == `EMC_STRAP_EXT) begin
      cnt <= 3'h0;
      src_lvl <= ext_clk_sync;
    end else if (cnt >= half) begin
      cnt <= 3'h0;
      src_lvl <= ~src_lvl;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  always_comb begin
    next_src_lvl = src_lvl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev <= 1'b0;
      tick <= 1'b0;
      clk_full <= 1'b0;
    end else begin
      ext_prev <= next_src_lvl;
      tick <= next_src_lvl & ~ext_prev;
      clk_full <= next_src_lvl;
    end
  end

  assign src_rise = next_src_lvl & ~ext_prev;

  // divide by 1, 2 or 4 counted on source rising edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
      clk_div <= 1'b0;
    end else if (div_sel == `EMC_DIV_BY1) begin
      div_cnt <= 2'h0;
      clk_div <= next_src_lvl;
    end else if (src_rise) begin
      div_cnt <= div_cnt + 2'h1;
      if (div_sel == `EMC_DIV_BY2)
        clk_div <= ~clk_div;
      else if (div_cnt[0])
        clk_div <= ~clk_div;
    end
  end
endmodule
`default_nettype wire

// ### hdl/emc_ctrl.sv
/*
  External memory interface control pins: chip-space select, byte
  enables, shared strobes for async / sdram / sync memories, fifo
  output enable, ready wait, host hold arbitration, interface clocks.
  Assumes a user-side access request held until o_ACK, and pins that
  are sampled through two flip-flops here. Strobes are active low.
*/
// Behaviour
// - byte enables decoded from low address bits
// - byte enables also serve as sdram mask
// - peripheral direct transfer output provided
// - hold acknowledge driven once bus granted
// - bus request output shows bus need
// - strapped address pins pick interface clock
// - external clock pin is the default
// - divided clock is input over 1,2,4
// - full clock runs at input clock rate
// - read pin shared per memory type
// - sync select zero gives address strobe
// - sync select one gives read enable
// - output enable pin shared per type
// - write pin shared per type
// - fifo output enable only for space three
// - exactly one chip enable per access
`default_nettype none
module emc_ctrl
  import emc_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_EXT_IF_CLOCK_IN,
  input wire logic [1:0] I_CLK_STRAP,
  input wire logic I_HOST_BUS_REQUEST_IN,
  input wire logic I_ASYNC_READY_IN,
  input wire logic [1:0] I_DIV_SEL,
  input wire logic I_REQ,
  input wire logic I_WRITE,
  input wire logic I_PDT,
  input wire logic I_WIDE16,
  input wire logic [1:0] I_MEM_TYPE,
  input wire logic I_READ_STROBE_SELECT,
  input wire logic [31:0] I_WORD_ADDR,
  input wire logic [1:0] I_BYTE_SIZE,
  output logic O_ACK,
  output logic O_BUS_GRANT_ACK_OUT,
  output logic O_BUS_NEED_OUT,
  output logic O_IF_CLOCK_OUT_FULL,
  output logic O_IF_CLOCK_OUT_DIVIDED,
  output logic [3:0] O_CHIP_SELECT_N,
  output logic O_BYTE_ENABLE_HI_N,
  output logic O_BYTE_ENABLE_LO_N,
  output logic O_READ_STROBE_N,
  output logic O_OUT_ENABLE_N,
  output logic O_WRITE_STROBE_N,
  output logic O_FIFO_SPACE_OUT_ENABLE_N,
  output logic O_PERIPH_DIRECT_XFER_N,
  output logic O_PINS_OE
);
  logic rst_meta, rst_n;
  logic [1:0] hold_s, rdy_s, eclk_s;
  logic [1:0] strap, strap_m, strap_s;
  logic strap_taken;
  logic tick;
  logic clk_full, clk_div;
  emc_state_t state, next_state;
  logic [3:0] tcnt;
  logic [1:0] space;
  logic granted;
  logic strobe_on;
  logic is_read;
  emc_mem_t mtype;
  logic hold_wait;

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_s <= 2'h0;
      rdy_s <= 2'h3;
      eclk_s <= 2'h0;
    end else begin
      hold_s <= {hold_s[0], I_HOST_BUS_REQUEST_IN};
      rdy_s <= {rdy_s[0], I_ASYNC_READY_IN};
      eclk_s <= {eclk_s[0], I_EXT_IF_CLOCK_IN};
    end
  end

  always_ff @(posedge I_MCLK) begin
    strap_m <= I_CLK_STRAP;
    strap_s <= strap_m;
  end
  // straps caught once on the first edge after release
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      strap <= `EMC_STRAP_EXT;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap <= (strap_s == 2'h3) ? `EMC_STRAP_EXT : strap_s;
      strap_taken <= 1'b1;
    end
  end

  emc_clkgen u_clkgen (
    .clk(I_MCLK),
    .rst_n(rst_n),
    .strap(strap),
    .div_sel(I_DIV_SEL),
    .ext_clk_sync(eclk_s[1]),
    .tick(tick),
    .clk_full(clk_full),
    .clk_div(clk_div)
  );

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_IF_CLOCK_OUT_FULL <= 1'b0;
      O_IF_CLOCK_OUT_DIVIDED <= 1'b0;
    end else begin
      O_IF_CLOCK_OUT_FULL <= clk_full;
      O_IF_CLOCK_OUT_DIVIDED <= clk_div;
    end
  end

  // hold is granted only between accesses, never mid-strobe
  assign hold_wait = hold_s[1] && state == EMC_ST_IDLE;

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      granted <= 1'b0;
    end else if (hold_wait) begin
      granted <= 1'b1;
    end else if (!hold_s[1]) begin
      granted <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BUS_GRANT_ACK_OUT <= 1'b0;
      O_BUS_NEED_OUT <= 1'b0;
      O_PINS_OE <= 1'b1;
    end else begin
      O_BUS_GRANT_ACK_OUT <= granted;
      O_BUS_NEED_OUT <= I_REQ | (state != EMC_ST_IDLE);
      O_PINS_OE <= ~granted;
    end
  end

  assign mtype = emc_mem_t'(I_MEM_TYPE);
  assign is_read = ~I_WRITE;
  assign space = I_WORD_ADDR[`EMC_SPACE_LSB +: 2];

  always_comb begin
    next_state = state;
    case (state)
      EMC_ST_IDLE: begin
        if (I_REQ && !granted && !hold_s[1])
          next_state = EMC_ST_SETUP;
      end
      EMC_ST_SETUP: begin
        if (tick)
          next_state = EMC_ST_STROBE;
      end
      EMC_ST_STROBE: begin
        // async wait: ready low stretches the strobe
        if (tick && tcnt == 4'h0 &&
            (mtype != EMC_MEM_ASYNC || rdy_s[1]))
          next_state = EMC_ST_DONE;
      end
      EMC_ST_DONE: begin
        next_state = EMC_ST_IDLE;
      end
      default: begin
        next_state = EMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= EMC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      tcnt <= 4'h0;
    end else if (state == EMC_ST_SETUP) begin
      tcnt <= `EMC_STROBE_TICKS;
    end else if (state == EMC_ST_STROBE && tick && tcnt != 4'h0) begin
      tcnt <= tcnt - 4'h1;
    end
  end

  assign strobe_on = (next_state == EMC_ST_STROBE);

  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_ACK <= 1'b0;
    end else begin
      O_ACK <= (next_state == EMC_ST_DONE);
    end
  end

  // one-hot space select, held over the whole access
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_CHIP_SELECT_N <= 4'hf;
    end else if (next_state == EMC_ST_IDLE) begin
      O_CHIP_SELECT_N <= 4'hf;
    end else begin
      O_CHIP_SELECT_N <= ~(4'h1 << space);
    end
  end

  // byte enables: 16-bit uses both lanes except byte size 0, which picks one lane by address bit 0; 8-bit only the low lane
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BYTE_ENABLE_HI_N <= 1'b1;
      O_BYTE_ENABLE_LO_N <= 1'b1;
    end else if (next_state == EMC_ST_IDLE) begin
      O_BYTE_ENABLE_HI_N <= 1'b1;
      O_BYTE_ENABLE_LO_N <= 1'b1;
    end else if (!I_WIDE16) begin
      O_BYTE_ENABLE_HI_N <= 1'b1;
      O_BYTE_ENABLE_LO_N <= 1'b0;
    end else if (I_BYTE_SIZE != 2'h0) begin
      O_BYTE_ENABLE_HI_N <= 1'b0;
      O_BYTE_ENABLE_LO_N <= 1'b0;
    end else begin
      // same lanes on reads and writes so they double as mask
      O_BYTE_ENABLE_HI_N <= ~I_WORD_ADDR[0];
      O_BYTE_ENABLE_LO_N <= I_WORD_ADDR[0];
    end
  end

  // shared strobe pins, meaning set by memory type of the space
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      O_READ_STROBE_N <= 1'b1;
      O_OUT_ENABLE_N <= 1'b1;
      O_WRITE_STROBE_N <= 1'b1;
      O_FIFO_SPACE_OUT_ENABLE_N <= 1'b1;
      O_PERIPH_DIRECT_XFER_N <= 1'b1;
    end else begin
      O_READ_STROBE_N <= 1'b1;
      O_OUT_ENABLE_N <= 1'b1;
      O_WRITE_STROBE_N <= 1'b1;
      O_FIFO_SPACE_OUT_ENABLE_N <= 1'b1;
      O_PERIPH_DIRECT_XFER_N <= ~(strobe_on & I_PDT);
      if (strobe_on) begin
        case (mtype)
          EMC_MEM_ASYNC: begin
            O_READ_STROBE_N <= ~is_read;
            O_OUT_ENABLE_N <= ~is_read;
            O_WRITE_STROBE_N <= is_read;
          end
          EMC_MEM_SDRAM: begin
            // column strobe, row strobe, write: short command form
            O_READ_STROBE_N <= 1'b0;
            O_OUT_ENABLE_N <= 1'b1;
            O_WRITE_STROBE_N <= is_read;
          end
          EMC_MEM_SYNC: begin
            // select 0: address strobe on every access
            // select 1: read enable on reads only
            O_READ_STROBE_N <= I_READ_STROBE_SELECT ? ~is_read : 1'b0;
            O_OUT_ENABLE_N <= ~is_read;
            O_WRITE_STROBE_N <= is_read;
            O_FIFO_SPACE_OUT_ENABLE_N <=
              ~(is_read && space == `EMC_FIFO_SPACE);
          end
          default: begin
            O_READ_STROBE_N <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/emc_map.svh
/*
  Constants of the external memory control-pin block: strap codes,
  chip-space decode, clock divide codes and access timing counts.
  Assumes inclusion from the package only; the modules get its macros through the package.
*/
`ifndef EMC_MAP_SVH
`define EMC_MAP_SVH

// strap codes on the two clock-select address pins
`define EMC_STRAP_EXT 2'h0
`define EMC_STRAP_DIV4 2'h1
`define EMC_STRAP_DIV6 2'h2
// divider terminal counts: half period of derived clock, minus one
`define EMC_HALF_DIV4 3'h1
`define EMC_HALF_DIV6 3'h2
// word address bits that pick the chip space
`define EMC_SPACE_LSB 26
`define EMC_SPACE_MSB 31
`define EMC_FIFO_SPACE 2'h3
// programmable divide of the second output clock
`define EMC_DIV_BY1 2'h0
`define EMC_DIV_BY2 2'h1
`define EMC_DIV_BY4 2'h2
// strobe active length in interface clock ticks, minus one
`define EMC_STROBE_TICKS 4'h3

`endif

// ### hdl/emc_pkg.sv
/*
  Types shared by the external memory control-pin block.
  Assumes emc_map.svh is on the include path.
*/
`default_nettype none
package emc_pkg;
  `include "emc_map.svh"

  typedef enum logic [1:0] {
    EMC_MEM_ASYNC = 2'h0,
    EMC_MEM_SDRAM = 2'h1,
    EMC_MEM_SYNC = 2'h2
  } emc_mem_t;

  // gray along idle -> setup -> strobe -> finish
  typedef enum logic [1:0] {
    EMC_ST_IDLE = 2'h0,
    EMC_ST_SETUP = 2'h1,
    EMC_ST_STROBE = 2'h3,
    EMC_ST_DONE = 2'h2
  } emc_state_t;
endpackage
`default_nettype wire

// ### sim/emc_ctrl_checker.sv
/* Port checker for emc_ctrl.
   Assumes a bind to emc_ctrl; access fields held until O_ACK. */
`default_nettype none
module emc_ctrl_checker (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_ASYNC_READY_IN,
  input wire logic I_PDT,
  input wire logic I_WIDE16,
  input wire logic I_REQ,
  input wire logic [1:0] I_BYTE_SIZE,
  input wire logic [31:0] I_WORD_ADDR,
  input wire logic O_ACK,
  input wire logic O_BUS_GRANT_ACK_OUT,
  input wire logic O_BUS_NEED_OUT,
  input wire logic O_PINS_OE,
  input wire logic [3:0] O_CHIP_SELECT_N,
  input wire logic O_BYTE_ENABLE_HI_N,
  input wire logic O_BYTE_ENABLE_LO_N,
  input wire logic O_WRITE_STROBE_N,
  input wire logic O_FIFO_SPACE_OUT_ENABLE_N,
  input wire logic O_PERIPH_DIRECT_XFER_N
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  wire logic sel = O_CHIP_SELECT_N != 4'hf;
  a_one_space: assert property (sel |-> $onehot(~O_CHIP_SELECT_N))
    else $error("more than one space selected");
  a_grant_quiet: assert property
    (O_BUS_GRANT_ACK_OUT |-> !sel && !O_PINS_OE)
    else $error("bus driven while granted");
  a_need_access: assert property (sel |-> O_BUS_NEED_OUT)
    else $error("access without bus request");
  a_fifo_space: assert property
    (!O_FIFO_SPACE_OUT_ENABLE_N |-> !O_CHIP_SELECT_N[3])
    else $error("fifo enable outside space three");
  a_ack_single: assert property (O_ACK |=> !O_ACK)
    else $error("ack longer than one cycle");
  a_byte_lane: assert property (I_REQ && !O_WRITE_STROBE_N && I_WIDE16
    && I_BYTE_SIZE == 2'h0 |-> O_BYTE_ENABLE_LO_N == I_WORD_ADDR[0]
    && O_BYTE_ENABLE_HI_N != I_WORD_ADDR[0])
    else $error("wrong byte lane");
  a_ready_wait: assert property (!I_ASYNC_READY_IN [*4] |-> !O_ACK)
    else $error("ack while ready low");
  a_pdt_only: assert property
    (!O_PERIPH_DIRECT_XFER_N |-> I_PDT && sel)
    else $error("stray direct transfer");
endmodule
`default_nettype wire

// ### sim/emc_ctrl_tb.sv
/* Self-checking bench for emc_ctrl with an async memory model.
   Assumes emc_pkg, the checker and the model compile first. */
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("unexpected at %0t: %0h not %0h", \
  $time, (a), (b)); end end
module emc_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, ext, host, rdy, req, wr, pdt, wide, rs;
  logic [1:0] strap, div, mt, bsz;
  logic [31:0] addr;
  logic [7:0] stall, sn;
  logic [3:0] cs_n, csm;
  logic ack, gnt, need, full, divo, hi_n, lo_n, rd_n, oe_n, we_n;
  logic fifo_n, pdt_n, pins_oe;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int lat, lat0;
  emc_ctrl dut (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_EXT_IF_CLOCK_IN(ext), .I_CLK_STRAP(strap),
    .I_HOST_BUS_REQUEST_IN(host), .I_ASYNC_READY_IN(rdy),
    .I_DIV_SEL(div), .I_REQ(req), .I_WRITE(wr), .I_PDT(pdt),
    .I_WIDE16(wide), .I_MEM_TYPE(mt), .I_READ_STROBE_SELECT(rs),
    .I_WORD_ADDR(addr), .I_BYTE_SIZE(bsz), .O_ACK(ack),
    .O_BUS_GRANT_ACK_OUT(gnt), .O_BUS_NEED_OUT(need),
    .O_IF_CLOCK_OUT_FULL(full), .O_IF_CLOCK_OUT_DIVIDED(divo),
    .O_CHIP_SELECT_N(cs_n), .O_BYTE_ENABLE_HI_N(hi_n),
    .O_BYTE_ENABLE_LO_N(lo_n), .O_READ_STROBE_N(rd_n),
    .O_OUT_ENABLE_N(oe_n), .O_WRITE_STROBE_N(we_n),
    .O_FIFO_SPACE_OUT_ENABLE_N(fifo_n),
    .O_PERIPH_DIRECT_XFER_N(pdt_n), .O_PINS_OE(pins_oe));
  emc_mem_model mem (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(we_n), .stall(stall), .ready(rdy));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // external interface clock: period of 8 system cycles
  always begin
    repeat (4) @(negedge clk);
    ext = ~ext;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task do_reset();
    rst_n = 1'h0;
    repeat (12) @(negedge clk);
    `CHK({cs_n, rd_n, we_n, pins_oe, ack, gnt}, 9'h1fc)
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask
  // one access; strobes seen low collect in sn, spaces in csm
  task acc(input logic [1:0] t, input logic w, s, p, wd,
    input logic [31:0] a, input logic [1:0] sz, input logic [7:0] st);
    {mt, wr, rs, pdt, wide, addr, bsz, stall} = {t, w, s, p, wd, a, sz, st};
    req = 1'h1;
    sn = 8'h0;
    csm = 4'h0;
    lat = 0;
    while (!ack && lat < 400) begin
      @(negedge clk);
      lat++;
      sn |= ~{1'h1, lo_n, hi_n, pdt_n, fifo_n, we_n, oe_n, rd_n};
      csm |= ~cs_n;
    end
    `CHK(ack, 1'h1)
    req = 1'h0;
    repeat (3) @(negedge clk);
    `CHK(rd_n & oe_n & we_n, 1'h1)
    `CHK(need, 1'h0)
  endtask
  task t_async();
    for (int i = 0; i < 4; i++) begin
      acc(2'h0, i[0], 1'h0, 1'h0, 1'h1, {4'h0, i[1:0], 26'h0}, 2'h1, 8'h0);
      `CHK(csm, 4'h1 << i)
      `CHK(sn[2:0], i[0] ? 3'h4 : 3'h3)
      `CHK(sn[6:5], 2'h3)
    end
  endtask
  task t_lanes();
    for (int j = 0; j < 6; j++) begin
      acc({1'h0, j[0]}, 1'h1, 1'h0, 1'h0, j < 4, {31'h0, j[1]}, 2'h0, 8'h0);
      `CHK(sn[6:5], (j < 4 && j[1]) ? 2'h1 : 2'h2)
    end
  endtask
  task t_sync();
    for (int k = 0; k < 8; k++) begin
      acc(2'h2, k[2], k[0], k[0], 1'h1, {5'h1, k[1], 26'h0}, 2'h1, 8'h0);
      `CHK(sn[0], !(k[0] && k[2]))
      `CHK(sn[2:1], k[2] ? 2'h2 : 2'h1)
      `CHK(sn[3], k[1] && !k[2])
      `CHK(sn[4], k[0])
    end
  endtask
  task t_stall();
    acc(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 32'h0, 2'h1, 8'h0);
    lat0 = lat;
    acc(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 32'h0, 2'h1, 8'h64);
    `CHK(lat >= lat0 + 60, 1'h1)
  endtask
  task t_hold();
    host = 1'h1;
    lat = 0;
    while (!gnt && lat < 60) begin
      @(negedge clk);
      lat++;
    end
    `CHK(gnt, 1'h1)
    `CHK(pins_oe, 1'h0)
    fork
      begin
        repeat (30) @(negedge clk);
        host = 1'h0;
      end
    join_none
    acc(2'h0, 1'h1, 1'h0, 1'h0, 1'h1, 32'h0, 2'h1, 8'h0);
    `CHK(lat > 30, 1'h1)
  endtask
  task t_clk(input logic [1:0] sp, dv, input int ef, ed);
    int nf, nd;
    logic pf, pd;
    strap = sp;
    div = dv;
    do_reset();
    {nf, nd, pf, pd} = {32'h0, 32'h0, full, divo};
    repeat (480) begin
      @(negedge clk);
      nf += full && !pf;
      nd += divo && !pd;
      {pf, pd} = {full, divo};
    end
    `CHK(nf >= ef - 1 && nf <= ef + 1, 1'h1)
    `CHK(nd >= ed - 1 && nd <= ed + 1, 1'h1)
  endtask
  initial begin
    {ext, host, req, wr, pdt, wide, rs, addr} = 39'h0;
    {strap, div, mt, bsz, stall} = 16'h0;
    do_reset();
    t_async();
    t_lanes();
    t_sync();
    t_stall();
    t_hold();
    t_clk(2'h0, 2'h0, 60, 60);
    t_clk(2'h1, 2'h1, 120, 60);
    t_clk(2'h2, 2'h2, 80, 20);
    t_clk(2'h3, 2'h1, 60, 30);
    end_of_test();
  end
endmodule
bind emc_ctrl emc_ctrl_checker chk (.I_MCLK, .I_RST_N, .I_ASYNC_READY_IN,
  .I_PDT, .I_WIDE16, .I_REQ, .I_BYTE_SIZE, .I_WORD_ADDR, .O_ACK,
  .O_BUS_GRANT_ACK_OUT, .O_BUS_NEED_OUT, .O_PINS_OE, .O_CHIP_SELECT_N,
  .O_BYTE_ENABLE_HI_N, .O_BYTE_ENABLE_LO_N, .O_WRITE_STROBE_N,
  .O_FIFO_SPACE_OUT_ENABLE_N, .O_PERIPH_DIRECT_XFER_N);
`default_nettype wire

// ### sim/emc_mem_model.sv
/* Async memory stand-in that drives the ready input.
   Assumes active-low strobes and a stall count from the bench. */
`default_nettype none
module emc_mem_model (
  input wire logic clk,
  input wire logic [3:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] stall,
  output logic ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt;
  wire logic idle = cs_n == 4'hf || (rd_n && wr_n);
  always_ff @(posedge clk) begin
    if (idle)
      cnt <= 8'h0;
    else if (cnt != 8'hff)
      cnt <= cnt + 8'h1;
  end
  // pin has a pull-up, so high whenever not strobed
  assign ready = idle || cnt >= stall;
endmodule
`default_nettype wire
